// >>> bench/mpm_monitor_sva.sv
// port assertions of the motor protection monitor
`timescale 1ns/1ps
`default_nettype none
module mpm_monitor_sva
  import mpm_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         ce,
  input wire mpm_meas_t    meas,
  input wire mpm_starter_t starter,
  input wire logic         thermal_trip,
  input wire logic         thermal_accum_hold,
  input wire logic [3:0]   fault_flags,
  input wire logic [2:0]   alarm_flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // trip, hold and overload alarm
  // ----
  chk_trip_sets: assert property (
    ce && meas.thermal_usage_percent >= 8'h64 && !starter.slow_speed && !starter.stopping
    |=> thermal_trip) else $error("trip missing at full usage");
  chk_trip_holds: assert property (
    (ce && thermal_trip && meas.thermal_usage_percent >= 8'h63)[*2] |=> thermal_trip)
    else $error("trip cleared above any reset level");
  chk_hold_cause: assert property (
    $rose(thermal_accum_hold) |-> $past(starter.start_cmd | starter.stop_cmd)
    || $past(starter.start_cmd | starter.stop_cmd, 2)) else $error("hold without command");
  chk_alarm_quiet: assert property (
    (ce && meas.thermal_usage_percent == 8'h00)[*2] |=> !alarm_flags[MPM_ALM_OVLD])
    else $error("overload alarm at zero usage");
  // ----
  // qualified conditions
  // ----
  // the lowest legal setting bounds the stall and high power causes, the highest one the low current and low power causes
  chk_stall_cause: assert property (
    $rose(fault_flags[MPM_FLT_STALL]) |-> $past(meas.peak_current_pct > 16'h0190)
    || $past(meas.peak_current_pct > 16'h0190, 2)) else $error("stall flag without cause");
  chk_lowcur_cause: assert property (
    $rose(fault_flags[MPM_FLT_LOWCUR]) || $rose(alarm_flags[MPM_ALM_LOWCUR])
    |-> $past(meas.phase_current_pct < 16'h0063) || $past(meas.phase_current_pct < 16'h0063, 2))
    else $error("low current flag without cause");
  chk_hipow_cause: assert property (
    $rose(fault_flags[MPM_FLT_HIPOW]) || $rose(alarm_flags[MPM_ALM_HIPOW])
    |-> $past(meas.real_power_kw != 16'h0000) || $past(meas.real_power_kw != 16'h0000, 2))
    else $error("high power flag at zero power");
  chk_lopow_cause: assert property (
    $rose(fault_flags[MPM_FLT_LOPOW]) |-> $past(meas.real_power_kw != 16'hffff)
    || $past(meas.real_power_kw != 16'hffff, 2)) else $error("low power flag at full scale");
endmodule
`default_nettype wire

// >>> bench/mpm_motor_model.sv
// behavioural motor and measurement front end feeding the monitor
`timescale 1ns/1ps
`default_nettype none
module mpm_motor_model
  import mpm_pkg::*;
(
  input  wire logic         aclk,
  input  wire mpm_meas_t    load,
  input  wire mpm_starter_t req,
  output var  mpm_meas_t    meas,
  output var  mpm_starter_t starter
);
  logic [1:0] cmd_ff;
  // ----
  // measurement and starter path
  // ----
  // one register of latency, as a real sampling front end has
  always_ff @(posedge aclk) begin
    cmd_ff <= {req.start_cmd, req.stop_cmd};
    meas <= load;
    starter.start_cmd <= req.start_cmd & ~cmd_ff[1];
    starter.stop_cmd <= req.stop_cmd & ~cmd_ff[0];
    starter.slow_speed <= req.slow_speed;
    starter.stopping <= req.stopping;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the motor protection monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
  import mpm_pkg::*;
;
  logic         aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [31:0]  s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hf, fault_flags;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid, thermal_trip, thermal_accum_hold;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic [2:0]   alarm_flags;
  mpm_meas_t    load = '0, meas;
  mpm_starter_t req = '0, starter;
  int           failures = 0, check_count = 0;
  logic [15:0]  rst_tab [16] = '{MPM_RST_OL_RESET_THR, MPM_RST_ZERO, MPM_RST_ZERO,
    MPM_RST_OL_ALARM_THR, MPM_RST_STALL_F_THR, MPM_RST_DELAY, MPM_RST_ZERO, MPM_RST_DELAY,
    MPM_RST_ZERO, MPM_RST_DELAY, MPM_RST_ZERO, MPM_RST_DELAY, MPM_RST_ZERO, MPM_RST_DELAY,
    MPM_RST_ZERO, MPM_RST_DELAY};
  always #10 aclk = ~aclk;
  // ten clocks per tenth of a second keeps every delay short
  mpm_monitor #(.TICK_CYCLES(10)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .starter, .thermal_trip,
    .thermal_accum_hold, .fault_flags, .alarm_flags);
  mpm_motor_model motor (.aclk, .load, .req, .meas, .starter);
  // ----
  // tasks
  // ----
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic stuck;
    failures++;
    give_verdict;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 50) stuck;
    chk(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 50) stuck;
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic put(input logic [7:0] u, input logic [15:0] pk, ph, pw);
    @(posedge aclk);
    load <= '{u, pk, ph, pw};
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < MPM_NCFG; i++) rd(8'h50 + 8'(i), 32'(rst_tab[i]), MPM_RESP_OKAY);
    rd(8'h00, 32'h0000_0000, MPM_RESP_SLVERR);
    wr(8'h70, 32'h0000_1234, MPM_RESP_SLVERR);
    wr(MPM_IDX_LOWCUR_F_THR, 32'h0000_0032, MPM_RESP_OKAY);
    rd(MPM_IDX_LOWCUR_F_THR, 32'h0000_0032, MPM_RESP_OKAY);
    wr(MPM_IDX_LOWCUR_A_THR, 32'h0000_0032, MPM_RESP_OKAY);
    wr(MPM_IDX_HIPOW_F_THR, 32'h0000_03e8, MPM_RESP_OKAY);
    wr(MPM_IDX_HIPOW_A_THR, 32'h0000_03e8, MPM_RESP_OKAY);
    wr(MPM_IDX_LOPOW_F_THR, 32'h0000_00c8, MPM_RESP_OKAY);
    wr(MPM_IDX_STALL_F_DLY, 32'h0000_0005, MPM_RESP_OKAY);
    // every condition but low power present, all enables still off
    put(8'h5f, 16'h02bc, 16'h001e, 16'h05dc);
    gap(80);
    chk(32'(fault_flags), 32'h0000_0000);
    chk(32'(alarm_flags), 32'h0000_0000);
    wr(MPM_IDX_FAULT_EN, 32'h0000_000f, MPM_RESP_OKAY);
    wr(MPM_IDX_ALARM_EN, 32'h0000_0007, MPM_RESP_OKAY);
    gap(80);
    chk(32'(fault_flags), 32'h0000_0007);
    chk(32'(alarm_flags), 32'h0000_0007);
    put(8'h32, 16'h0064, 16'h0064, 16'h01f4);
    gap(30);
    chk(32'(alarm_flags), 32'h0000_0000);
    put(8'h32, 16'h0064, 16'h0064, 16'h0064);
    gap(30);
    chk(32'(fault_flags), 32'h0000_000f);
    put(8'h32, 16'h0064, 16'h0064, 16'h01f4);
    wr(MPM_IDX_STATUS, 32'h0000_00f0, MPM_RESP_OKAY);
    rd(MPM_IDX_STATUS, 32'h0000_0000, MPM_RESP_OKAY);
    // a one-cycle drop must restart the stall timer
    put(8'h32, 16'h02bc, 16'h0064, 16'h01f4);
    gap(30);
    put(8'h32, 16'h0064, 16'h0064, 16'h01f4);
    put(8'h32, 16'h02bc, 16'h0064, 16'h01f4);
    gap(30);
    chk(32'(fault_flags), 32'h0000_0000);
    gap(40);
    chk(32'(fault_flags), 32'h0000_0001);
    put(8'h64, 16'h0064, 16'h0064, 16'h01f4);
    gap(5);
    chk(32'(thermal_trip), 32'h0000_0001);
    put(8'h50, 16'h0064, 16'h0064, 16'h01f4);
    wr(MPM_IDX_CONTROL, 32'h0000_0002, MPM_RESP_OKAY);
    gap(3);
    chk(32'(thermal_trip), 32'h0000_0001);
    put(8'h46, 16'h0064, 16'h0064, 16'h01f4);
    wr(MPM_IDX_CONTROL, 32'h0000_0002, MPM_RESP_OKAY);
    gap(3);
    chk(32'(thermal_trip), 32'h0000_0000);
    wr(MPM_IDX_CONTROL, 32'h0000_0001, MPM_RESP_OKAY);
    put(8'h64, 16'h0064, 16'h0064, 16'h01f4);
    gap(5);
    put(8'h46, 16'h0064, 16'h0064, 16'h01f4);
    gap(5);
    chk(32'(thermal_trip), 32'h0000_0000);
    wr(MPM_IDX_CONTROL, 32'h0000_0000, MPM_RESP_OKAY);
    wr(MPM_IDX_OL_SHUNT, 32'h0000_0002, MPM_RESP_OKAY);
    wr(MPM_IDX_OL_INHIBIT, 32'h0000_0002, MPM_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      req <= '{k == 0, k == 1, 1'h0, 1'h0};
      gap(50);
      chk(32'(thermal_accum_hold), 32'h0000_0001);
      req <= '0;
      gap(250);
      chk(32'(thermal_accum_hold), 32'h0000_0000);
    end
    // each maneuver opens a two-second window without trips
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      req <= '{1'h0, 1'h0, k == 0, k == 1};
      put(8'h64, 16'h0064, 16'h0064, 16'h01f4);
      gap(50);
      chk(32'(thermal_trip), 32'h0000_0000);
      chk(32'(thermal_accum_hold), 32'h0000_0000);
      gap(250);
      chk(32'(thermal_trip), 32'h0000_0001);
      req <= '0;
      put(8'h46, 16'h0064, 16'h0064, 16'h01f4);
      wr(MPM_IDX_CONTROL, 32'h0000_0002, MPM_RESP_OKAY);
    end
    give_verdict;
  end
  initial begin
    repeat (100000) @(posedge aclk);
    stuck;
  end
endmodule
bind mpm_monitor mpm_monitor_sva u_sva (.aclk, .aresetn, .ce, .meas, .starter, .thermal_trip,
  .thermal_accum_hold, .fault_flags, .alarm_flags);
`default_nettype wire

// >>> design/mpm_monitor.sv
// motor protection monitor: thermal trip control, qualified faults and alarms, axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - after a thermal trip, reset only allowed once usage is below reset threshold
// - with auto restart on, trip clears itself when usage drops below threshold
// - usage accumulation held for shunt seconds after any start or stop command
// - trip suppressed for inhibit seconds during slow speed or stopping maneuvers
// - accumulation continues normally while trip is inhibited
// - overload alarm when usage exceeds alarm level and alarm bit enabled
// - stall fault when peak current exceeds level for the delay, if enabled
// - stall delay 0.1 to 100.0 s, condition must persist whole delay
// - low current fault when current stays below level for delay, if enabled
// - low current fault delay 0.1 to 99.0 s of continuous low current
// - low current alarm when current stays below alarm level for delay, if enabled
// - low current alarm delay 0.1 to 99.0 s continuous
// - high power fault when power exceeds level for delay, if enabled
// - high power fault delay 0.1 to 99.0 s, continuously above level
// - high power alarm when power exceeds alarm level for delay, if enabled
// - high power alarm delay 0.1 to 99.0 s, continuously above level
// - low power fault when power stays below level for delay, if enabled
// - low power fault delay 0.1 to 99.0 s, continuously below level
module mpm_monitor
  import mpm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MPM_TENTH_CYCLES
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire mpm_meas_t    meas,
  input  wire mpm_starter_t starter,
  output logic              thermal_trip,
  output logic              thermal_accum_hold,
  output logic [3:0]        fault_flags,
  output logic [2:0]        alarm_flags
);
  // -------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr[1:0] == 2'b00) && (addr[31:10] == 22'h0)
              && (addr[9:2] >= MPM_IDX_OL_RESET_THR) && (addr[9:2] <= MPM_IDX_USAGE);
  endfunction

  function automatic logic [15:0] cfg_reset(input int i);
    case (i)
      0:       cfg_reset = MPM_RST_OL_RESET_THR;
      3:       cfg_reset = MPM_RST_OL_ALARM_THR;
      4:       cfg_reset = MPM_RST_STALL_F_THR;
      5, 7, 9, 11, 13, 15: cfg_reset = MPM_RST_DELAY;
      default: cfg_reset = MPM_RST_ZERO;
    endcase
  endfunction

  logic [15:0] cfg_ff [0:MPM_NCFG-1];
  logic [3:0]  fault_en_ff;
  logic [2:0]  alarm_en_ff;
  logic        auto_restart_ff;
  logic        trip_ff;
  logic        hold_ff;
  logic [3:0]  fault_ff;
  logic [2:0]  alarm_ff;
  logic        inhibit_on;

  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        do_write;
  logic [7:0]  widx;

  assign do_write = !awready_ff && !wready_ff && !bvalid_ff;
  assign widx     = awaddr_ff[9:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= MPM_RESP_OKAY;
      awaddr_ff  <= 32'h0000_0000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (ce) begin
      if (awready_ff && s_axi_awvalid) begin
        awready_ff <= 1'b0;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (wready_ff && s_axi_wvalid) begin
        wready_ff <= 1'b0;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= reg_hit(awaddr_ff) ? MPM_RESP_OKAY : MPM_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  logic wr_ok;
  logic wr_lo;
  logic wr_hi;
  assign wr_ok = do_write && reg_hit(awaddr_ff);
  assign wr_lo = wstrb_ff[0];
  assign wr_hi = wstrb_ff[1];

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  for (genvar g = 0; g < MPM_NCFG; g++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_ff[g] <= cfg_reset(g);
      end else if (ce && wr_ok && (widx == MPM_IDX_OL_RESET_THR + 8'(g))) begin
        if (wr_lo) begin
          cfg_ff[g][7:0] <= wdata_ff[7:0];
        end
        if (wr_hi) begin
          cfg_ff[g][15:8] <= wdata_ff[15:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_en_ff     <= MPM_RST_EN_MASK[3:0];
      alarm_en_ff     <= MPM_RST_EN_MASK[2:0];
      auto_restart_ff <= 1'b0;
    end else if (ce && wr_ok && wr_lo) begin
      if (widx == MPM_IDX_FAULT_EN) begin
        fault_en_ff <= wdata_ff[3:0];
      end
      if (widx == MPM_IDX_ALARM_EN) begin
        alarm_en_ff <= wdata_ff[2:0];
      end
      if (widx == MPM_IDX_CONTROL) begin
        auto_restart_ff <= wdata_ff[MPM_CTL_AUTORST];
      end
    end
  end

  // one-cycle strobes decoded from software writes
  logic       ol_reset_req;
  logic [3:0] fault_clr;
  assign ol_reset_req = wr_ok && wr_lo && (widx == MPM_IDX_CONTROL)
                        && wdata_ff[MPM_CTL_OLRESET];
  assign fault_clr    = (wr_ok && wr_lo && (widx == MPM_IDX_STATUS))
                        ? wdata_ff[MPM_STS_FLT_LSB +: 4] : 4'h0;

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rd_mux;
  logic [7:0]  ridx;
  logic [15:0] status_word;

  assign ridx        = s_axi_araddr[9:2];
  assign status_word = {2'b00, inhibit_on, hold_ff, 1'b0, alarm_ff, fault_ff, 3'b000, trip_ff};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ridx >= MPM_IDX_OL_RESET_THR && ridx <= MPM_IDX_LOPOW_F_DLY) begin
      rd_mux[15:0] = cfg_ff[4'(ridx - MPM_IDX_OL_RESET_THR)];
    end else begin
      case (ridx)
        MPM_IDX_FAULT_EN: rd_mux[3:0]  = fault_en_ff;
        MPM_IDX_ALARM_EN: rd_mux[2:0]  = alarm_en_ff;
        MPM_IDX_CONTROL:  rd_mux[0]    = auto_restart_ff;
        MPM_IDX_STATUS:   rd_mux[15:0] = status_word;
        MPM_IDX_USAGE:    rd_mux[7:0]  = meas.thermal_usage_percent;
        default:          rd_mux       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= MPM_RESP_OKAY;
    end else if (ce) begin
      if (arready_ff && s_axi_arvalid) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= reg_hit(s_axi_araddr) ? rd_mux : 32'h0000_0000;
        rresp_ff   <= reg_hit(s_axi_araddr) ? MPM_RESP_OKAY : MPM_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // timebase: tenth-second and second ticks
  // -------------------------------------------------------------
  logic [31:0] tick_cnt_ff;
  logic [3:0]  tenth_cnt_ff;
  logic        tenth_tick;
  logic        sec_tick;
  assign tenth_tick = (tick_cnt_ff == TICK_CYCLES - 1);
  assign sec_tick   = tenth_tick && (tenth_cnt_ff == MPM_TENTHS_PER_SEC - 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_ff  <= 32'h0000_0000;
      tenth_cnt_ff <= 4'h0;
    end else if (ce) begin
      tick_cnt_ff <= tenth_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      if (tenth_tick) begin
        tenth_cnt_ff <= sec_tick ? 4'h0 : tenth_cnt_ff + 4'h1;
      end
    end
  end

  // -------------------------------------------------------------
  // thermal trip, shunt and inhibit
  // -------------------------------------------------------------
  logic [15:0] shunt_cnt_ff;
  logic [15:0] inhib_cnt_ff;
  logic        maneuver;
  logic        maneuver_d_ff;
  logic        below_reset;
  assign maneuver    = starter.slow_speed || starter.stopping;
  assign below_reset = {8'h00, meas.thermal_usage_percent} < cfg_ff[0];
  // inhibit window opens at the start of each maneuver; accumulation is untouched
  assign inhibit_on  = maneuver
                       && ((maneuver_d_ff ? inhib_cnt_ff : cfg_ff[2]) != 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shunt_cnt_ff <= 16'h0000;
      hold_ff      <= 1'b0;
    end else if (ce) begin
      if (starter.start_cmd || starter.stop_cmd) begin
        shunt_cnt_ff <= cfg_ff[1];
        hold_ff      <= cfg_ff[1] != 16'h0000;
      end else begin
        if (sec_tick && shunt_cnt_ff != 16'h0000) begin
          shunt_cnt_ff <= shunt_cnt_ff - 16'h0001;
        end
        hold_ff <= !(sec_tick && shunt_cnt_ff == 16'h0001) && shunt_cnt_ff != 16'h0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inhib_cnt_ff  <= 16'h0000;
      maneuver_d_ff <= 1'b0;
    end else if (ce) begin
      maneuver_d_ff <= maneuver;
      if (maneuver && !maneuver_d_ff) begin
        inhib_cnt_ff <= cfg_ff[2];
      end else if (!maneuver) begin
        inhib_cnt_ff <= 16'h0000;
      end else if (sec_tick && inhib_cnt_ff != 16'h0000) begin
        inhib_cnt_ff <= inhib_cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_ff <= 1'b0;
    end else if (ce) begin
      // a fresh trip condition beats a reset in the same cycle
      if (meas.thermal_usage_percent >= MPM_TRIP_LEVEL && !inhibit_on) begin
        trip_ff <= 1'b1;
      end else if (trip_ff && below_reset && (auto_restart_ff || ol_reset_req)) begin
        trip_ff <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // qualification timers
  // -------------------------------------------------------------
  // order: stall f, low current f, low current a, high power f, high power a, low power f
  localparam int NQ = 6;
  logic [NQ-1:0] q_cond;
  logic [NQ-1:0] q_done;
  logic [15:0]   q_dly [0:NQ-1];

  assign q_cond[0] = meas.peak_current_pct > cfg_ff[4];
  assign q_cond[1] = meas.phase_current_pct < cfg_ff[6];
  assign q_cond[2] = meas.phase_current_pct < cfg_ff[8];
  assign q_cond[3] = meas.real_power_kw > cfg_ff[10];
  assign q_cond[4] = meas.real_power_kw > cfg_ff[12];
  assign q_cond[5] = meas.real_power_kw < cfg_ff[14];
  assign q_dly[0]  = cfg_ff[5];
  assign q_dly[1]  = cfg_ff[7];
  assign q_dly[2]  = cfg_ff[9];
  assign q_dly[3]  = cfg_ff[11];
  assign q_dly[4]  = cfg_ff[13];
  assign q_dly[5]  = cfg_ff[15];

  for (genvar q = 0; q < NQ; q++) begin : g_qual
    logic [15:0] cnt_ff;
    logic [15:0] lim;
    // a zero delay would qualify instantly, so it is held to the 0.1 s minimum
    assign lim       = (q_dly[q] == 16'h0000) ? MPM_RST_DELAY : q_dly[q];
    assign q_done[q] = q_cond[q] && (cnt_ff >= lim);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_ff <= 16'h0000;
      end else if (ce) begin
        if (!q_cond[q]) begin
          cnt_ff <= 16'h0000;
        end else if (tenth_tick && cnt_ff < lim) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // fault latches and alarm levels
  // -------------------------------------------------------------
  logic [3:0] fault_set;
  assign fault_set = {q_done[5], q_done[3], q_done[1], q_done[0]} & fault_en_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_ff <= 4'h0;
      alarm_ff <= 3'h0;
    end else if (ce) begin
      // set wins over a write-one-to-clear in the same cycle
      fault_ff <= fault_set | (fault_ff & ~fault_clr);
      alarm_ff[MPM_ALM_OVLD]   <= alarm_en_ff[MPM_ALM_OVLD]
                                  && ({8'h00, meas.thermal_usage_percent} > cfg_ff[3]);
      alarm_ff[MPM_ALM_LOWCUR] <= alarm_en_ff[MPM_ALM_LOWCUR] && q_done[2];
      alarm_ff[MPM_ALM_HIPOW]  <= alarm_en_ff[MPM_ALM_HIPOW] && q_done[4];
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign s_axi_awready      = awready_ff;
  assign s_axi_wready       = wready_ff;
  assign s_axi_bvalid       = bvalid_ff;
  assign s_axi_bresp        = bresp_ff;
  assign s_axi_arready      = arready_ff;
  assign s_axi_rvalid       = rvalid_ff;
  assign s_axi_rdata        = rdata_ff;
  assign s_axi_rresp        = rresp_ff;
  assign thermal_trip       = trip_ff;
  assign thermal_accum_hold = hold_ff;
  assign fault_flags        = fault_ff;
  assign alarm_flags        = alarm_ff;
endmodule
`default_nettype wire

// >>> design/mpm_pkg.sv
// package: register map, field layout, timing and carrier types of the motor protection monitor
package mpm_pkg;
  // -------------------------------------------------------------
  // register indices (byte address is four times the index)
  // -------------------------------------------------------------
  localparam logic [7:0] MPM_IDX_OL_RESET_THR   = 8'h50;
  localparam logic [7:0] MPM_IDX_OL_SHUNT       = 8'h51;
  localparam logic [7:0] MPM_IDX_OL_INHIBIT     = 8'h52;
  localparam logic [7:0] MPM_IDX_OL_ALARM_THR   = 8'h53;
  localparam logic [7:0] MPM_IDX_STALL_F_THR    = 8'h54;
  localparam logic [7:0] MPM_IDX_STALL_F_DLY    = 8'h55;
  localparam logic [7:0] MPM_IDX_LOWCUR_F_THR   = 8'h56;
  localparam logic [7:0] MPM_IDX_LOWCUR_F_DLY   = 8'h57;
  localparam logic [7:0] MPM_IDX_LOWCUR_A_THR   = 8'h58;
  localparam logic [7:0] MPM_IDX_LOWCUR_A_DLY   = 8'h59;
  localparam logic [7:0] MPM_IDX_HIPOW_F_THR    = 8'h5a;
  localparam logic [7:0] MPM_IDX_HIPOW_F_DLY    = 8'h5b;
  localparam logic [7:0] MPM_IDX_HIPOW_A_THR    = 8'h5c;
  localparam logic [7:0] MPM_IDX_HIPOW_A_DLY    = 8'h5d;
  localparam logic [7:0] MPM_IDX_LOPOW_F_THR    = 8'h5e;
  localparam logic [7:0] MPM_IDX_LOPOW_F_DLY    = 8'h5f;
  localparam logic [7:0] MPM_IDX_FAULT_EN       = 8'h60;
  localparam logic [7:0] MPM_IDX_ALARM_EN       = 8'h61;
  localparam logic [7:0] MPM_IDX_CONTROL        = 8'h62;
  localparam logic [7:0] MPM_IDX_STATUS         = 8'h63;
  localparam logic [7:0] MPM_IDX_USAGE          = 8'h64;
  localparam int         MPM_NCFG               = 16;
  // -------------------------------------------------------------
  // reset values (levels in percent or kW, delays in 0.1 s units)
  // -------------------------------------------------------------
  localparam logic [15:0] MPM_RST_OL_RESET_THR  = 16'h004b;
  localparam logic [15:0] MPM_RST_OL_ALARM_THR  = 16'h005a;
  localparam logic [15:0] MPM_RST_STALL_F_THR   = 16'h0258;
  localparam logic [15:0] MPM_RST_DELAY         = 16'h0001;
  localparam logic [15:0] MPM_RST_ZERO          = 16'h0000;
  localparam logic [7:0]  MPM_RST_EN_MASK       = 8'h00;
  localparam logic [7:0]  MPM_TRIP_LEVEL        = 8'h64;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int MPM_FLT_STALL   = 0;
  localparam int MPM_FLT_LOWCUR  = 1;
  localparam int MPM_FLT_HIPOW   = 2;
  localparam int MPM_FLT_LOPOW   = 3;
  localparam int MPM_ALM_OVLD    = 0;
  localparam int MPM_ALM_LOWCUR  = 1;
  localparam int MPM_ALM_HIPOW   = 2;
  localparam int MPM_CTL_AUTORST = 0;
  localparam int MPM_CTL_OLRESET = 1;
  localparam int MPM_STS_TRIP    = 0;
  localparam int MPM_STS_FLT_LSB = 4;
  localparam int MPM_STS_ALM_LSB = 8;
  localparam int MPM_STS_HOLD    = 12;
  localparam int MPM_STS_INHIB   = 13;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int MPM_CLK_PERIOD_NS = 20;
  localparam int MPM_TENTH_NS      = 100_000_000;
  localparam int MPM_TENTH_CYCLES  = MPM_TENTH_NS / MPM_CLK_PERIOD_NS;
  localparam logic [3:0] MPM_TENTHS_PER_SEC = 4'ha;
  localparam logic [1:0] MPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MPM_RESP_SLVERR = 2'h2;
  // -------------------------------------------------------------
  // carrier types
  // -------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  thermal_usage_percent;
    logic [15:0] peak_current_pct;
    logic [15:0] phase_current_pct;
    logic [15:0] real_power_kw;
  } mpm_meas_t;
  typedef struct packed {
    logic start_cmd;
    logic stop_cmd;
    logic slow_speed;
    logic stopping;
  } mpm_starter_t;
endpackage
